// >>> shared/tcd_params.svh
// constants of the tape control datapath
`ifndef TCD_PARAMS_SVH
`define TCD_PARAMS_SVH
`define TCD_CLK_MHZ 125
`define TCD_SERVICE_NS 266000
`define TCD_CMD_DEV 7'h68
`define TCD_STS_DEV 7'h69
`define TCD_CMD_W 15
`define TCD_STS_STOP 0
`define TCD_STS_ENB_LSB 1
`define TCD_STS_MAINT 8
`define TCD_STS_SIM_TICK 9
`define TCD_STS_SIM_MARK 10
`define TCD_STS_CLR_MISS 11
`define TCD_OP_NOP 3'h7
`define TCD_OP_WR_BIT 2
`define TCD_LAST_LINE 4'hB
`define TCD_MID_LINE 4'h6
`define TCD_HALF_READ_LINE 4'h5
`define TCD_ENB_MISS 0
`define TCD_ENB_PAR 1
`endif

// >>> shared/tcd_pkg.sv
// types and decode functions of the tape control datapath
`default_nettype none
`include "tcd_params.svh"
package tcd_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_XFER = 5'h02,
		ST_CK0 = 5'h04,
		ST_CK1 = 5'h08,
		ST_DONE = 5'h10
	} tcd_state_e;

	typedef struct packed {
		logic [2:0] flag_chan;
		logic [2:0] data_chan;
		logic [2:0] op;
		logic [3:0] unit;
		logic [1:0] motion;
	} tcd_cmd_s;

	function automatic logic op_is_write(input logic [2:0] op);
		return op[`TCD_OP_WR_BIT] && (op != `TCD_OP_NOP);
	endfunction : op_is_write
endpackage : tcd_pkg
`default_nettype wire

// >>> shared/tcd_core_if.sv
// checksum and data request signals between the core and its helpers
`timescale 1ns/1ps
`default_nettype none
interface tcd_core_if;
	logic lp_clear;
	logic lp_fold;
	logic lp_raw;
	logic [5:0] lp_in;
	logic [5:0] lp_val;
	logic req_set;
	logic req_clr;
	logic missed_clr;
	logic req_pend;
	logic req_missed;
	modport core (output lp_clear, lp_fold, lp_raw, lp_in, req_set, req_clr,
		missed_clr, input lp_val, req_pend, req_missed);
	modport lp (input lp_clear, lp_fold, lp_raw, lp_in, output lp_val);
	modport req (input req_set, req_clr, missed_clr,
		output req_pend, req_missed);
endinterface : tcd_core_if
`default_nettype wire

// >>> rtl/tcd_checksum.sv
// six bit longitudinal checksum register
`timescale 1ns/1ps
`default_nettype none
module tcd_checksum (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// core side
	tcd_core_if.lp c
);
	logic [5:0] lp_q, lp_d, fold_v;

	always_comb begin
		fold_v = c.lp_raw ? c.lp_in : ~c.lp_in; // RULE19
		lp_d = lp_q;
		if (c.lp_clear) begin
			lp_d = c.lp_fold ? fold_v : 6'h00;
		end else if (c.lp_fold) begin
			lp_d = lp_q ^ fold_v; // RULE19 RULE21
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lp_q <= 6'h00;
		end else begin
			lp_q <= lp_d;
		end
	end

	assign c.lp_val = lp_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_lp_fold_inv: assert property (c.lp_fold && !c.lp_raw && !c.lp_clear
		|=> lp_q == ($past(lp_q) ^ ~$past(c.lp_in))) // RULE19
		else $error("checksum did not fold inverted group");
	a_lp_fold_raw: assert property (c.lp_fold && c.lp_raw && !c.lp_clear
		|=> lp_q == ($past(lp_q) ^ $past(c.lp_in))) // RULE21
		else $error("checksum did not fold tape checksum");
endmodule : tcd_checksum
`default_nettype wire

// >>> rtl/tcd_req_timer.sv
// data request flag with service deadline and missed flag
`timescale 1ns/1ps
`default_nettype none
module tcd_req_timer #(
	parameter int unsigned SERVICE_CYCLES = 33250
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// core side
	tcd_core_if.req c
);
	localparam int W = $clog2(SERVICE_CYCLES + 1);
	logic req_q, req_d, miss_q, miss_d;
	logic [W-1:0] cnt_q, cnt_d;
	logic late;

	always_comb begin
		late = req_q && (cnt_q == W'(SERVICE_CYCLES - 1));
		req_d = req_q;
		cnt_d = cnt_q;
		miss_d = miss_q;
		// count runs one past the deadline so the miss fires once
		if (req_q && cnt_q != W'(SERVICE_CYCLES)) begin
			cnt_d = cnt_q + W'(1);
		end
		if (c.req_clr) begin
			req_d = 1'b0; // RULE24
		end
		if (c.req_set) begin
			req_d = 1'b1;
			cnt_d = '0;
		end
		if (c.missed_clr) begin
			miss_d = 1'b0;
		end
		if (late && !c.req_clr) begin
			miss_d = 1'b1; // RULE25
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req_q <= 1'b0;
			miss_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			req_q <= req_d;
			miss_q <= miss_d;
			cnt_q <= cnt_d;
		end
	end

	assign c.req_pend = req_q;
	assign c.req_missed = miss_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_req_miss_late: assert property (late && !c.req_clr |=> miss_q) // RULE25
		else $error("late request did not set missed flag");
	a_req_clr_drop: assert property (c.req_clr && !c.req_set |=> !req_q) // RULE24
		else $error("serviced request still pending");
	c_req_missed: cover property (req_q ##1 miss_q);
endmodule : tcd_req_timer
`default_nettype wire

// >>> rtl/tcd_datapath.sv
// tape control datapath: command, status, buffer, shift and line logic
// How it works
// (RULE1) 36-bit parallel bus carries data and control
// (RULE2) control output loads the command register
// (RULE3) data output word captured in buffer
// (RULE4) write word goes to shift register by halves
// (RULE5) shift register hands out 6-bit groups
// (RULE6) word written as twelve 3-bit lines
// (RULE7) read lines gathered into 6-bit groups
// (RULE8) read data loaded to buffer in halves
// (RULE9) data input drives buffer onto bus
// (RULE10) processor can simulate mark and timing
// (RULE11) device address picks command or status
// (RULE12) 2-bit motion field: go, direction
// (RULE13) 4-bit unit field with new-unit bit
// (RULE14) 3-bit operation field selects function
// (RULE15) two 3-bit interrupt channel fields
// (RULE16) 7 enables written, 28 conditions readable
// (RULE17) buffer halves feed shift register
// (RULE18) line buffer upper writes, lower reads
// (RULE19) inverted groups folded into checksum
// (RULE20) checksum written as two lines
// (RULE21) read checksum folded, all ones passes
// (RULE22) mixer routes sources to buffer or shifter
// (RULE23) block end checks parity, flags error
// (RULE24) transfer clears pending data request
// (RULE25) late service sets data missed
// (RULE26) stop finishes block, then job done
// (RULE27) unused operation code moves no data
`timescale 1ns/1ps
`default_nettype none
`include "tcd_params.svh"
module tcd_datapath #(
	parameter int unsigned SERVICE_CYCLES =
		`TCD_SERVICE_NS * `TCD_CLK_MHZ / 1000,
	parameter logic [6:0] CMD_DEV = `TCD_CMD_DEV,
	parameter logic [6:0] STS_DEV = `TCD_STS_DEV
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// processor bus
	input wire logic [6:0] dev_addr,
	input wire logic control_output_instr,
	input wire logic control_input_instr,
	input wire logic data_output_instr,
	input wire logic data_input_instr,
	input wire logic [35:0] bus_data_in,
	output logic [35:0] bus_data_out,
	output logic bus_data_oe,
	// tape side
	input wire logic timing_tick,
	input wire logic block_mark,
	input wire logic [2:0] read_lines,
	output logic [2:0] write_lines,
	output logic write_en,
	output logic tape_go,
	output logic tape_reverse,
	output logic [2:0] unit_sel,
	output logic unit_new,
	output logic [2:0] data_chan,
	output logic [2:0] flag_chan,
	// flags
	output logic data_request,
	output logic data_missed,
	output logic parity_error,
	output logic job_done
);
	if (SERVICE_CYCLES < 2) begin : g_chk
		$error("SERVICE_CYCLES must be at least 2");
	end

	tcd_core_if c ();

	tcd_checksum u_lp (
		.clk(clk),
		.rst_n(rst_n),
		.c(c.lp)
	);

	tcd_req_timer #(.SERVICE_CYCLES(SERVICE_CYCLES)) u_req (
		.clk(clk),
		.rst_n(rst_n),
		.c(c.req)
	);

	tcd_pkg::tcd_state_e st_q, st_d;
	tcd_pkg::tcd_cmd_s cmd_q, cmd_d, cmd_in;
	logic [6:0] enb_q, enb_d;
	logic maint_q, maint_d, stop_q, stop_d, fresh_q, fresh_d;
	logic [35:0] buf_q, buf_d, dout_q, dout_d;
	logic [17:0] sr_q, sr_d, src, nsr;
	logic [5:0] lb_q, lb_d, grp, lp_cur;
	logic [3:0] line_q, line_d;
	logic [2:0] wl_q, wl_d;
	logic doe_q, doe_d, we_q, we_d, done_q, done_d, perr_q, perr_d;
	logic sel_cmd, sel_sts, cmd_wr, sts_wr, tick, mark, wr, err_halt;
	logic [27:0] status;

	always_comb begin
		sel_cmd = (dev_addr == CMD_DEV); // RULE11
		sel_sts = (dev_addr == STS_DEV); // RULE11
		cmd_wr = control_output_instr && sel_cmd;
		sts_wr = control_output_instr && sel_sts;
		cmd_in = tcd_pkg::tcd_cmd_s'(bus_data_in[`TCD_CMD_W-1:0]);
		// simulated timing and mark replace tape in maintenance
		tick = maint_q ? (sts_wr && bus_data_in[`TCD_STS_SIM_TICK])
			: timing_tick; // RULE10
		mark = maint_q ? bus_data_in[`TCD_STS_SIM_MARK] : block_mark;
		wr = tcd_pkg::op_is_write(cmd_q.op); // RULE14
		err_halt = (c.req_missed && enb_q[`TCD_ENB_MISS])
			|| (perr_q && enb_q[`TCD_ENB_PAR]); // RULE16
		// second half sits in the upper half after the first shift
		src = (line_q == 4'h0 || line_q == `TCD_MID_LINE)
			? buf_q[35:18] : sr_q; // RULE17
		nsr = {sr_q[11:0], lb_q[2:0], read_lines};
		lp_cur = fresh_q ? 6'h00 : c.lp_val; // RULE19 RULE21
		status = {perr_q, c.req_missed, done_q, c.req_pend, stop_q,
			maint_q, we_q, st_q, enb_q, cmd_q.op, cmd_q.motion,
			cmd_q.unit}; // RULE16
	end

	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		enb_d = enb_q;
		maint_d = maint_q;
		stop_d = stop_q;
		fresh_d = fresh_q;
		buf_d = buf_q;
		sr_d = sr_q;
		lb_d = lb_q;
		line_d = line_q;
		wl_d = wl_q;
		done_d = done_q;
		perr_d = perr_q;
		dout_d = 36'h0_0000_0000;
		doe_d = 1'b0;
		grp = 6'h00;
		c.lp_clear = 1'b0;
		c.lp_fold = 1'b0;
		c.lp_raw = 1'b0;
		c.lp_in = 6'h00;
		c.req_set = 1'b0;
		c.req_clr = 1'b0;
		c.missed_clr = 1'b0;
		case (st_q)
			tcd_pkg::ST_IDLE: begin
				line_d = 4'h0;
			end
			tcd_pkg::ST_XFER: begin
				if (err_halt) begin
					st_d = tcd_pkg::ST_IDLE;
				end else if (tick && mark && line_q == 4'h0) begin
					st_d = tcd_pkg::ST_CK0; // RULE23
				end else if (tick) begin
					line_d = (line_q == `TCD_LAST_LINE) ? 4'h0
						: line_q + 4'h1; // RULE6
					if (wr && !line_q[0]) begin
						grp = src[17:12]; // RULE5 RULE22
						sr_d = {src[11:0], 6'h00}; // RULE4 RULE5
						wl_d = grp[5:3]; // RULE18
						lb_d = {grp[2:0], 3'h0};
						if (line_q == 4'h0) begin
							buf_d = {buf_q[17:0], 18'h0_0000}; // RULE17
						end
						if (line_q == `TCD_MID_LINE) begin
							c.req_set = 1'b1;
						end
					end else if (wr) begin
						wl_d = lb_q[5:3]; // RULE6 RULE18
						lb_d = {lb_q[2:0], 3'h0};
					end else begin
						lb_d = {lb_q[2:0], read_lines}; // RULE7 RULE18
						if (line_q[0]) begin
							grp = {lb_q[2:0], read_lines}; // RULE7
							sr_d = nsr; // RULE22
							if (line_q == `TCD_HALF_READ_LINE) begin
								buf_d[35:18] = nsr; // RULE8
							end
							if (line_q == `TCD_LAST_LINE) begin
								buf_d[17:0] = nsr; // RULE8
								c.req_set = 1'b1;
							end
						end
					end
					if (wr ? !line_q[0] : line_q[0]) begin
						c.lp_fold = 1'b1; // RULE19
						c.lp_in = grp;
						c.lp_clear = fresh_q;
						fresh_d = 1'b0;
					end
				end
			end
			tcd_pkg::ST_CK0: begin
				if (tick) begin
					st_d = tcd_pkg::ST_CK1;
					if (wr) begin
						wl_d = lp_cur[5:3]; // RULE20
						lb_d = {lp_cur[2:0], 3'h0}; // RULE20 RULE22
					end else begin
						lb_d = {lb_q[2:0], read_lines};
					end
				end
			end
			tcd_pkg::ST_CK1: begin
				if (tick) begin
					if (wr) begin
						wl_d = lb_q[5:3]; // RULE20
					end else begin
						grp = {lb_q[2:0], read_lines};
						c.lp_fold = 1'b1; // RULE21
						c.lp_raw = 1'b1;
						c.lp_in = grp;
						if (!(&(lp_cur ^ grp))) begin
							perr_d = 1'b1; // RULE21 RULE23
						end
					end
					fresh_d = 1'b1;
					line_d = 4'h0;
					if (stop_q) begin
						st_d = tcd_pkg::ST_DONE; // RULE26
						done_d = 1'b1;
					end else begin
						st_d = tcd_pkg::ST_XFER;
					end
				end
			end
			tcd_pkg::ST_DONE: begin
				st_d = tcd_pkg::ST_IDLE; // RULE26
			end
			default: begin
				st_d = tcd_pkg::ST_IDLE;
			end
		endcase
		if (cmd_wr) begin
			cmd_d = cmd_in; // RULE2 RULE12 RULE13 RULE14 RULE15
			st_d = (cmd_in.op == `TCD_OP_NOP) ? tcd_pkg::ST_IDLE
				: tcd_pkg::ST_XFER; // RULE27
			done_d = done_d && !done_q; // a flag set this cycle wins
			stop_d = 1'b0;
			perr_d = perr_d && !perr_q;
			fresh_d = 1'b1;
			line_d = 4'h0;
			c.missed_clr = 1'b1;
			c.req_set = tcd_pkg::op_is_write(cmd_in.op);
		end
		if (sts_wr) begin
			enb_d = bus_data_in[`TCD_STS_ENB_LSB+:7]; // RULE16
			maint_d = bus_data_in[`TCD_STS_MAINT];
			if (bus_data_in[`TCD_STS_STOP]) begin
				stop_d = 1'b1; // RULE26
			end
			if (bus_data_in[`TCD_STS_CLR_MISS]) begin
				c.missed_clr = 1'b1;
			end
		end
		if (data_output_instr && sel_cmd) begin
			buf_d = bus_data_in; // RULE1 RULE3
			c.req_clr = 1'b1; // RULE24
		end
		if (data_input_instr && sel_cmd) begin
			dout_d = buf_q; // RULE9
			doe_d = 1'b1;
			c.req_clr = 1'b1; // RULE24
		end else if (control_input_instr && sel_cmd) begin
			dout_d = {21'h00_0000, cmd_q}; // RULE2
			doe_d = 1'b1;
		end else if (control_input_instr && sel_sts) begin
			dout_d = {8'h00, status}; // RULE16
			doe_d = 1'b1;
		end
		we_d = tcd_pkg::op_is_write(cmd_d.op)
			&& (st_d == tcd_pkg::ST_XFER || st_d == tcd_pkg::ST_CK0
			|| st_d == tcd_pkg::ST_CK1);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= tcd_pkg::ST_IDLE;
			cmd_q <= '0;
			enb_q <= 7'h00;
			maint_q <= 1'b0;
			stop_q <= 1'b0;
			fresh_q <= 1'b1;
			buf_q <= 36'h0_0000_0000;
			sr_q <= 18'h0_0000;
			lb_q <= 6'h00;
			line_q <= 4'h0;
			wl_q <= 3'h0;
			we_q <= 1'b0;
			done_q <= 1'b0;
			perr_q <= 1'b0;
			dout_q <= 36'h0_0000_0000;
			doe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			enb_q <= enb_d;
			maint_q <= maint_d;
			stop_q <= stop_d;
			fresh_q <= fresh_d;
			buf_q <= buf_d;
			sr_q <= sr_d;
			lb_q <= lb_d;
			line_q <= line_d;
			wl_q <= wl_d;
			we_q <= we_d;
			done_q <= done_d;
			perr_q <= perr_d;
			dout_q <= dout_d;
			doe_q <= doe_d;
		end
	end

	assign bus_data_out = dout_q;
	assign bus_data_oe = doe_q;
	assign write_lines = wl_q;
	assign write_en = we_q;
	assign tape_go = cmd_q.motion[1]; // RULE12
	assign tape_reverse = cmd_q.motion[0]; // RULE12
	assign unit_sel = cmd_q.unit[2:0]; // RULE13
	assign unit_new = cmd_q.unit[3]; // RULE13
	assign data_chan = cmd_q.data_chan; // RULE15
	assign flag_chan = cmd_q.flag_chan; // RULE15
	assign data_request = c.req_pend;
	assign data_missed = c.req_missed;
	assign parity_error = perr_q;
	assign job_done = done_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_cmd_load: assert property (cmd_wr
		|=> cmd_q == $past(bus_data_in[`TCD_CMD_W-1:0])) // RULE2
		else $error("command register not loaded");
	a_nop_idle: assert property (cmd_wr && cmd_in.op == `TCD_OP_NOP
		|=> st_q == tcd_pkg::ST_IDLE && !write_en) // RULE27
		else $error("unused operation started a transfer");
	a_data_input_instr_bus: assert property (data_input_instr && sel_cmd
		|=> bus_data_oe && bus_data_out == $past(buf_q)) // RULE9
		else $error("buffer not driven on data input");
	a_wr_line_upper: assert property (st_q == tcd_pkg::ST_XFER && tick && wr
		&& !err_halt && !mark && !line_q[0] && !cmd_wr
		|=> write_lines == $past(src[17:15])) // RULE18
		else $error("write line not taken from upper group bits");
	a_ck_parity: assert property (st_q == tcd_pkg::ST_CK1 && tick && !wr
		&& !cmd_wr && !(&(lp_cur ^ {lb_q[2:0], read_lines}))
		|=> parity_error) // RULE21
		else $error("bad block checksum not flagged");
	a_stop_done: assert property (st_q == tcd_pkg::ST_CK1 && tick && stop_q
		&& !cmd_wr |=> job_done ##1 st_q == tcd_pkg::ST_IDLE) // RULE26
		else $error("stop did not end in job done and idle");
	c_write_word: cover property (we_q && line_q == `TCD_LAST_LINE);
	c_read_ck: cover property (st_q == tcd_pkg::ST_CK1 && !wr && tick);
	c_job_done: cover property (job_done);
endmodule : tcd_datapath
`default_nettype wire

// >>> bench/tcd_tape_model.sv
// tape transport model: timing ticks, mark level, read and written lines
`timescale 1ns/1ps
`default_nettype none
module tcd_tape_model (
	// clock
	input wire logic clk,
	// tape lines
	input wire logic [2:0] write_lines,
	output logic timing_tick,
	output logic block_mark,
	output logic [2:0] read_lines
);
	initial begin
		timing_tick = 1'b0;
		block_mark = 1'b0;
		read_lines = 3'h0;
	end

	// one tape line: tick with mark and read data, then the written line
	task automatic line(input logic mark, input logic [2:0] rd,
		output logic [2:0] wr);
		@(posedge clk);
		timing_tick <= 1'b1;
		block_mark <= mark;
		read_lines <= rd;
		@(posedge clk);
		timing_tick <= 1'b0;
		// released head shows no stale value
		read_lines <= ~rd;
		#1;
		wr = write_lines;
	endtask : line
endmodule : tcd_tape_model
`default_nettype wire

// >>> bench/tb_tape_control_datapath.sv
// self-checking testbench of the tape control datapath
`timescale 1ns/1ps
`default_nettype none
`include "tcd_params.svh"
module tb_tape_control_datapath;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] dev_addr = 7'h00;
	logic control_output_instr = 1'b0;
	logic control_input_instr = 1'b0;
	logic data_output_instr = 1'b0;
	logic data_input_instr = 1'b0;
	logic [35:0] bus_data_in = 36'h0;
	logic [35:0] bus_data_out;
	logic bus_data_oe;
	logic timing_tick, block_mark, write_en, tape_go, tape_reverse;
	logic [2:0] read_lines, write_lines, unit_sel, data_chan, flag_chan;
	logic unit_new, data_request, data_missed, parity_error, job_done;
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [35:0] q, e;
	logic [5:0] cs;
	logic [2:0] w;
	logic got;
	localparam logic [35:0] WA = 36'h7A5C3E19B;
	localparam logic [35:0] RA = 36'h5D2B4C6E1;
	localparam logic [35:0] WB = 36'hD6B5A4931;

	always #4 clk = ~clk;

	tcd_datapath #(.SERVICE_CYCLES(20)) uut (
		.clk(clk), .rst_n(rst_n), .dev_addr(dev_addr),
		.control_output_instr(control_output_instr),
		.control_input_instr(control_input_instr),
		.data_output_instr(data_output_instr),
		.data_input_instr(data_input_instr),
		.bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe), .timing_tick(timing_tick),
		.block_mark(block_mark), .read_lines(read_lines),
		.write_lines(write_lines), .write_en(write_en),
		.tape_go(tape_go), .tape_reverse(tape_reverse),
		.unit_sel(unit_sel), .unit_new(unit_new),
		.data_chan(data_chan), .flag_chan(flag_chan),
		.data_request(data_request), .data_missed(data_missed),
		.parity_error(parity_error), .job_done(job_done)
	);

	tcd_tape_model tape (
		.clk(clk), .write_lines(write_lines), .timing_tick(timing_tick),
		.block_mark(block_mark), .read_lines(read_lines)
	);

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk(input logic [35:0] g, input logic [35:0] x);
		tests_run++;
		if (g !== x) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : hold

	// one-cycle write pulse: kind 0 control output, 1 data output
	task automatic put(input logic kind, input logic [6:0] dev,
		input logic [35:0] d);
		@(posedge clk);
		dev_addr <= dev;
		bus_data_in <= d;
		control_output_instr <= !kind;
		data_output_instr <= kind;
		@(posedge clk);
		control_output_instr <= 1'b0;
		data_output_instr <= 1'b0;
		#1;
	endtask : put

	// level read: dat 1 data input, 0 control input
	task automatic get(input logic [6:0] dev, input logic dat);
		@(posedge clk);
		dev_addr <= dev;
		data_input_instr <= dat;
		control_input_instr <= !dat;
		got = 1'b0;
		// answer is registered: look just after each edge
		repeat (3) begin
			@(posedge clk);
			#1;
			if (!got && bus_data_oe === 1'b1) begin
				got = 1'b1;
				q = bus_data_out;
			end
		end
		if (!got) q = bus_data_out;
		@(posedge clk);
		data_input_instr <= 1'b0;
		control_input_instr <= 1'b0;
		#1;
	endtask : get

	function automatic logic [5:0] lsum(input logic [35:0] d);
		logic [5:0] s;
		s = 6'h0;
		for (int k = 0; k < 6; k++) begin
			s = s ^ ~d[35-6*k -: 6];
		end
		return s;
	endfunction : lsum

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		hold(1);
		get(`TCD_STS_DEV, 1'b0);
		chk(q, 36'h000010000);
		chk({31'h0, write_en, data_request, data_missed, parity_error,
			job_done}, 36'h0);
		$display("reset test done");

		put(1'b0, `TCD_CMD_DEV, 36'h00000566B);
		get(`TCD_CMD_DEV, 1'b0);
		chk(q, 36'h00000566B);
		chk({28'h0, tape_go, tape_reverse, data_chan, flag_chan}, 36'hDD);
		chk({32'h0, unit_new, unit_sel}, 36'hA);
		for (int i = 0; i < 8; i++) begin
			put(1'b0, `TCD_CMD_DEV, {27'h0, i[2:0], 4'h0, i[1:0]});
			get(`TCD_STS_DEV, 1'b0);
			e = {28'h0, i[2] && i != 7, (i == 7) ? 5'h01 : 5'h02, i[1:0]};
			chk({28'h0, q[21:16], tape_go, tape_reverse}, e);
		end
		$display("command test done");

		put(1'b0, `TCD_STS_DEV, 36'h0AA);
		get(`TCD_STS_DEV, 1'b0);
		chk({29'h0, q[15:9]}, 36'h55);
		put(1'b0, `TCD_STS_DEV, 36'h0);
		put(1'b0, 7'h00, 36'h0000000FF);
		get(7'h00, 1'b0);
		chk({35'h0, got}, 36'h0);
		get(`TCD_CMD_DEV, 1'b0);
		chk(q, 36'h1C3);
		$display("status and decode test done");

		put(1'b0, `TCD_CMD_DEV, 36'h102);
		chk({35'h0, data_request}, 36'h1);
		put(1'b1, `TCD_CMD_DEV, WA);
		chk({35'h0, data_request}, 36'h0);
		put(1'b0, `TCD_STS_DEV, 36'h1);
		for (int i = 0; i < 12; i++) begin
			tape.line(1'b0, 3'h0, w);
			chk({33'h0, w}, {33'h0, WA[35-3*i -: 3]});
			if (i == 6) chk({35'h0, data_request}, 36'h1);
		end
		cs = lsum(WA);
		tape.line(1'b1, 3'h0, w);
		tape.line(1'b0, 3'h0, w);
		chk({33'h0, w}, {33'h0, cs[5:3]});
		tape.line(1'b0, 3'h0, w);
		chk({33'h0, w}, {33'h0, cs[2:0]});
		hold(3);
		get(`TCD_STS_DEV, 1'b0);
		chk({30'h0, q[25], q[20:16]}, {30'h0, 1'b1, 5'h01});
		chk({35'h0, job_done}, 36'h1);
		$display("write stream test done");

		put(1'b0, `TCD_CMD_DEV, 36'h102);
		hold(17);
		chk({35'h0, data_missed}, 36'h0);
		hold(6);
		chk({35'h0, data_missed}, 36'h1);
		put(1'b0, `TCD_STS_DEV, 36'h800);
		chk({35'h0, data_missed}, 36'h0);
		get(`TCD_CMD_DEV, 1'b1);
		chk({35'h0, data_request}, 36'h0);
		$display("service test done");

		put(1'b0, `TCD_CMD_DEV, 36'h2);
		for (int i = 0; i < 12; i++) begin
			tape.line(1'b0, RA[35-3*i -: 3], w);
		end
		chk({35'h0, data_request}, 36'h1);
		get(`TCD_CMD_DEV, 1'b1);
		chk(q, RA);
		cs = ~lsum(RA);
		tape.line(1'b1, 3'h0, w);
		tape.line(1'b0, cs[5:3], w);
		tape.line(1'b0, cs[2:0], w);
		hold(2);
		chk({35'h0, parity_error}, 36'h0);
		tape.line(1'b1, 3'h0, w);
		tape.line(1'b0, 3'h0, w);
		tape.line(1'b0, 3'h0, w);
		hold(2);
		chk({35'h0, parity_error}, 36'h1);
		$display("read stream test done");

		put(1'b0, `TCD_CMD_DEV, 36'h102);
		put(1'b1, `TCD_CMD_DEV, WB);
		put(1'b0, `TCD_STS_DEV, 36'h100);
		put(1'b0, `TCD_STS_DEV, 36'h300);
		hold(2);
		chk({33'h0, write_lines}, {33'h0, WB[35:33]});
		tape.line(1'b0, 3'h0, w);
		put(1'b0, `TCD_STS_DEV, 36'h300);
		hold(2);
		chk({33'h0, write_lines}, {33'h0, WB[32:30]});
		put(1'b0, `TCD_CMD_DEV, 36'h102);
		put(1'b0, `TCD_STS_DEV, 36'h700);
		get(`TCD_STS_DEV, 1'b0);
		chk({31'h0, q[20:16]}, 36'h4);
		put(1'b0, `TCD_STS_DEV, 36'h0);
		$display("maintenance test done");
		end_sim();
	end
endmodule : tb_tape_control_datapath
`default_nettype wire
